// *** rtl/fis_seq.sv ***
// Purpose: fault isolation automatism sequencer, mode keeping and remote indications
// Assumes: event inputs are levels from other logic, pins pass two flip-flops
// Notes:   an open that gets no breaker-open status in time counts as failed
`timescale 1ns/1ps
// Summary of operation
// (R01) the enable setting switches the whole automatism and shows on an enabled output.
// (R02) on becoming enabled the automatism starts idle and Manual, Automatic only on command.
// (R03) remote mode commands act only while the selector is in remote.
// (R04) local mode commands act only while the selector is in local.
// (R05) remote mode commands are ignored when disabled or not in remote.
// (R06) auto-mode indication is high only when enabled and Automatic.
// (R07) in Automatic, each fault-passage detection until the set count raises the fault counter by one.
// (R08) at the set count the direction of the first fault is checked against the allowed set.
// (R09) with an allowed direction, wait the voltage-absence time, then command an open.
// (R10) after a good opening go idle and keep the present mode.
// (R11) after a failed opening go idle and force Manual until a valid Automatic command.
// (R12) each open command gives a one-cycle pulse on the operation output.
// (R13) with a fault recorded, voltage present past the maximum wait ends the cycle.
// (R14) while disabled both remote indications are zero with the invalid qualifier set.
// (R15) detector or overcurrent units disabled also force zero plus invalid.
// (R16) returning to idle clears the counter and any pending absence wait.
// (R17) outgoing, incoming and unknown directions each have their own allow flag.
module fis_seq #(
    parameter int unsigned OPEN_TMO_MS = fis_pkg::OPEN_TMO_MS_DEF,
    parameter int unsigned TICK_CYC    = fis_pkg::TICK_CYC
) (
    input  wire logic             i_mclk,
    input  wire logic             i_rst_n,
    input  wire fis_pkg::fis_cfg_t i_cfg,
    input  wire fis_pkg::fis_dir_t i_fault_dir,
    input  wire logic             i_fault_passage_detector,
    input  wire logic             i_voltage_present,
    input  wire logic             i_voltage_absent,
    input  wire logic             i_breaker_open,
    input  wire logic             i_sel_remote,
    input  wire logic             i_loc_to_auto,
    input  wire logic             i_loc_to_man,
    input  wire logic             i_rem_to_auto,
    input  wire logic             i_rem_to_man,
    output logic                  o_enabled,
    output logic                  o_pickup,
    output logic                  o_check_error,
    output logic                  o_open_cmd,
    output logic                  o_automatic_state_led,
    output logic                  o_manual_state_led,
    output fis_pkg::fis_rc_t      o_rc
);
    logic [1:0]            rst_sync_q;
    logic                  rst_n;
    logic [1:0]            pin_s1_q;
    logic [1:0]            pin_s2_q;
    logic                  brk_open;
    logic                  sel_remote;
    fis_pkg::fis_state_t   state_q;
    logic                  auto_q;
    logic                  en_q;
    logic [fis_pkg::CNT_W-1:0] cnt_q;
    logic                  fpd_q;
    logic                  fpd_rise;
    fis_pkg::fis_dir_t     first_dir_q;
    logic                  dir_ok;
    logic                  enabled;
    logic                  blocked;
    logic                  go_idle;
    logic                  open_good;
    logic                  open_fail;
    logic                  fire;
    logic                  t_abs_clr;
    logic                  t_vp_clr;
    logic [fis_pkg::TIME_W-1:0] abs_ms;
    logic [fis_pkg::TIME_W-1:0] vp_ms;
    logic                  cmd_auto;
    logic                  cmd_man;

    function automatic logic [fis_pkg::TIME_W-1:0] s_to_ms(input logic [16:0] v);
        s_to_ms = v;
    endfunction : s_to_ms

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // breaker status and selector are pins
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_q <= 2'h0;
            pin_s2_q <= 2'h0;
        end else begin
            pin_s1_q <= {i_breaker_open, i_sel_remote};
            pin_s2_q <= pin_s1_q;
        end
    end
    assign brk_open   = pin_s2_q[1];
    assign sel_remote = pin_s2_q[0];

    assign enabled = i_cfg.enable; // R01
    assign blocked = !i_cfg.fpd_en || !i_cfg.vpres_en || !i_cfg.vabs_en
                     || !i_cfg.ovc_any_en; // R15

    // allowed directions, an invalid direction counts as unknown
    always_comb begin
        if (!first_dir_q.valid) begin
            dir_ok = i_cfg.dir_unk_ok; // R17
        end else if (first_dir_q.forward) begin
            dir_ok = i_cfg.dir_out_ok; // R17
        end else begin
            dir_ok = i_cfg.dir_in_ok; // R17
        end
    end

    assign fpd_rise = i_fault_passage_detector && !fpd_q;
    assign fire     = (state_q == fis_pkg::FIS_WAIT_ABS) && i_voltage_absent
                      && (abs_ms >= i_cfg.abs_time_ms); // R09
    assign open_good = (state_q == fis_pkg::FIS_WAIT_OPEN) && brk_open; // R10
    assign open_fail = (state_q == fis_pkg::FIS_WAIT_OPEN) && !brk_open
                       && (abs_ms >= fis_pkg::TIME_W'(OPEN_TMO_MS)); // R11
    assign go_idle = (state_q == fis_pkg::FIS_COUNT || state_q == fis_pkg::FIS_WAIT_ABS)
                     && i_voltage_present
                     && (vp_ms >= s_to_ms(i_cfg.max_wait_ms)); // R13

    // remote and local both gated by selector only; enable acts in the mode register
    assign cmd_auto = (sel_remote && i_rem_to_auto) || (!sel_remote && i_loc_to_auto); // R03 R04
    assign cmd_man  = (sel_remote && i_rem_to_man) || (!sel_remote && i_loc_to_man); // R03 R04

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            en_q  <= 1'b0;
            fpd_q <= 1'b0;
        end else begin
            en_q  <= enabled;
            fpd_q <= i_fault_passage_detector;
        end
    end

    // mode: disabled input ignores commands entirely
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            auto_q <= 1'b0;
        end else if (!enabled || !en_q) begin
            auto_q <= 1'b0; // R02 R05
        end else if (open_fail) begin
            auto_q <= 1'b0; // R11
        end else if (cmd_man) begin
            auto_q <= 1'b0; // R03 R04
        end else if (cmd_auto) begin
            auto_q <= 1'b1; // R02
        end
    end

    // cycle sequencing only in Automatic
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_q     <= fis_pkg::FIS_IDLE;
            cnt_q       <= '0;
            first_dir_q <= '0;
        end else if (!enabled || !auto_q || blocked) begin
            state_q <= fis_pkg::FIS_IDLE; // R02
            cnt_q   <= '0; // R16
        end else begin
            case (state_q)
                fis_pkg::FIS_IDLE: begin
                    cnt_q <= '0; // R16
                    if (fpd_rise) begin
                        cnt_q       <= fis_pkg::CNT_W'(1); // R07
                        first_dir_q <= i_fault_dir;
                        state_q     <= fis_pkg::FIS_COUNT;
                    end
                end
                fis_pkg::FIS_COUNT: begin
                    if (go_idle) begin
                        state_q <= fis_pkg::FIS_IDLE; // R13
                    end else if (cnt_q >= i_cfg.num_faults) begin
                        state_q <= dir_ok ? fis_pkg::FIS_WAIT_ABS
                                          : fis_pkg::FIS_IDLE; // R08
                    end else if (fpd_rise) begin
                        cnt_q <= cnt_q + 1'b1; // R07
                    end
                end
                fis_pkg::FIS_WAIT_ABS: begin
                    if (go_idle) begin
                        state_q <= fis_pkg::FIS_IDLE; // R13
                    end else if (fire) begin
                        state_q <= fis_pkg::FIS_WAIT_OPEN; // R09
                    end
                end
                fis_pkg::FIS_WAIT_OPEN: begin
                    if (open_good || open_fail) begin
                        state_q <= fis_pkg::FIS_IDLE; // R10 R11
                    end
                end
                default: state_q <= fis_pkg::FIS_IDLE;
            endcase
        end
    end

    // absence wait restarts in FIS_WAIT_ABS whenever voltage is not absent; reused as open timeout
    assign t_abs_clr = (state_q == fis_pkg::FIS_IDLE) || (state_q == fis_pkg::FIS_COUNT)
                       || ((state_q == fis_pkg::FIS_WAIT_ABS) && !i_voltage_absent)
                       || fire; // R16
    assign t_vp_clr  = !i_voltage_present || (state_q == fis_pkg::FIS_IDLE);

    fis_timer #(.TICK_CYC(TICK_CYC)) u_abs_timer (
        .i_clk   (i_mclk),
        .i_rst_n (rst_n),
        .i_clr   (t_abs_clr),
        .i_run   (1'b1),
        .o_ms    (abs_ms)
    );

    fis_timer #(.TICK_CYC(TICK_CYC)) u_vp_timer (
        .i_clk   (i_mclk),
        .i_rst_n (rst_n),
        .i_clr   (t_vp_clr),
        .i_run   (1'b1),
        .o_ms    (vp_ms)
    );

    // outputs registered; invalid forces zero indications
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            o_enabled             <= 1'b0;
            o_pickup              <= 1'b0;
            o_check_error         <= 1'b0;
            o_open_cmd            <= 1'b0;
            o_automatic_state_led <= 1'b0;
            o_manual_state_led    <= 1'b0;
            o_rc                  <= '0;
        end else begin
            o_enabled             <= enabled; // R01
            o_pickup              <= state_q != fis_pkg::FIS_IDLE;
            o_check_error         <= enabled && blocked;
            o_open_cmd            <= fire;
            o_automatic_state_led <= enabled && auto_q;
            o_manual_state_led    <= enabled && !auto_q;
            if (!enabled || blocked) begin
                o_rc <= '{auto_mode: 1'b0, operation: 1'b0,
                          invalid_qualifier: 1'b1}; // R14 R15
            end else begin
                o_rc <= '{auto_mode: auto_q, operation: fire,
                          invalid_qualifier: 1'b0}; // R06 R12
            end
        end
    end
endmodule : fis_seq

// *** rtl/fis_pkg.sv ***
// Purpose: shared constants and types for the fault isolation sequencer
// Assumes: 100 MHz clock, times in seconds at 1 ms resolution
// Notes:   settings arrive as plain ports grouped in a struct
package fis_pkg;
    localparam int unsigned CLK_HZ          = 100_000_000;
    localparam int unsigned TICK_MS         = 1;
    localparam int unsigned TICK_CYC        = CLK_HZ / 1000 * TICK_MS;
    localparam int unsigned CNT_W           = 3;
    localparam int unsigned TIME_W          = 17;
    localparam logic [2:0]  NUM_FAULTS_DEF  = 3'h2;
    localparam int unsigned ABS_TIME_S_DEF  = 5;
    localparam int unsigned MAX_WAIT_S_DEF  = 10;
    localparam int unsigned MS_PER_S        = 1000;
    localparam int unsigned OPEN_TMO_MS_DEF = 200;
    localparam int unsigned OP_PULSE_CYC    = 1;

    typedef struct packed {
        logic        enable;
        logic [2:0]  num_faults;
        logic [16:0] abs_time_ms;
        logic [16:0] max_wait_ms;
        logic        dir_out_ok;
        logic        dir_in_ok;
        logic        dir_unk_ok;
        logic        fpd_en;
        logic        vpres_en;
        logic        vabs_en;
        logic        ovc_any_en;
    } fis_cfg_t;

    typedef struct packed {
        logic valid;
        logic forward;
    } fis_dir_t;

    typedef struct packed {
        logic auto_mode;
        logic operation;
        logic invalid_qualifier;
    } fis_rc_t;

    typedef enum logic [1:0] {
        FIS_IDLE,
        FIS_COUNT,
        FIS_WAIT_ABS,
        FIS_WAIT_OPEN
    } fis_state_t;
endpackage : fis_pkg

// *** rtl/fis_timer.sv ***
// Purpose: millisecond tick divider plus elapsed-time counter
// Assumes: i_clr restarts the count from zero
// Notes:   counter saturates so long waits never wrap
`timescale 1ns/1ps
module fis_timer #(
    parameter int unsigned TICK_CYC = fis_pkg::TICK_CYC,
    parameter int unsigned TIME_W   = fis_pkg::TIME_W
) (
    input  wire logic              i_clk,
    input  wire logic              i_rst_n,
    input  wire logic              i_clr,
    input  wire logic              i_run,
    output logic      [TIME_W-1:0] o_ms
);
    localparam int unsigned DIV_W = $clog2(TICK_CYC);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_CYC - 1);
    logic [DIV_W-1:0] div_q;
    logic             tick;

    assign tick = (div_q == DIV_LAST);

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            div_q <= '0;
        end else if (i_clr || tick) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_ms <= '0;
        end else if (i_clr) begin
            o_ms <= '0;
        end else if (i_run && tick && (o_ms != '1)) begin
            o_ms <= o_ms + 1'b1;
        end
    end
endmodule : fis_timer

// *** bench/fis_seq_props.sv ***
// Purpose: port assertions for fis_seq
// Assumes: one clock, pin inputs pass two flip-flops
// Notes:   disable, blocked and mode checks wait for the reset sync to settle
`timescale 1ns/1ps
module fis_seq_props (
    input wire logic              i_mclk,
    input wire logic              i_rst_n,
    input wire fis_pkg::fis_cfg_t i_cfg,
    input wire logic              i_sel_remote,
    input wire logic              i_loc_to_auto,
    input wire logic              i_loc_to_man,
    input wire logic              i_rem_to_auto,
    input wire logic              i_rem_to_man,
    input wire logic              o_enabled,
    input wire logic              o_pickup,
    input wire logic              o_open_cmd,
    input wire logic              o_automatic_state_led,
    input wire logic              o_manual_state_led,
    input wire fis_pkg::fis_rc_t  o_rc
);
    logic [2:0] age_q;
    logic [2:0] hi_q;
    logic [2:0] lo_q;
    wire logic  live = (age_q == 3'h7);
    wire logic  blk  = !(i_cfg.fpd_en && i_cfg.vpres_en && i_cfg.vabs_en && i_cfg.ovc_any_en);
    // selector must sit still past the pin sync before mode checks apply
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            age_q <= 3'h0;
            hi_q  <= 3'h0;
            lo_q  <= 3'h0;
        end else begin
            age_q <= live ? age_q : age_q + 3'h1;
            hi_q  <= !i_sel_remote ? 3'h0 : (hi_q == 3'h7) ? hi_q : hi_q + 3'h1;
            lo_q  <= i_sel_remote ? 3'h0 : (lo_q == 3'h7) ? lo_q : lo_q + 3'h1;
        end
    end
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);
    property p_dis;
        (live && !i_cfg.enable) [*3] |-> !o_enabled && !o_manual_state_led && o_rc == 3'h1;
    endproperty
    a_dis: assert property (p_dis) else $error("disabled outputs wrong");
    property p_blk;
        (live && blk) [*3] |-> o_rc.invalid_qualifier && !o_rc.auto_mode;
    endproperty
    a_blk: assert property (p_blk) else $error("blocked unit not invalid");
    property p_led;
        o_rc.auto_mode |-> o_automatic_state_led && o_enabled && !o_manual_state_led;
    endproperty
    a_led: assert property (p_led) else $error("auto mode without enable");
    property p_op;
        o_open_cmd |-> o_rc.operation ##1 (!o_open_cmd && !o_rc.operation);
    endproperty
    a_op: assert property (p_op) else $error("operation pulse wrong");
    property p_open;
        o_open_cmd |-> $past(o_pickup) && $past(o_automatic_state_led);
    endproperty
    a_open: assert property (p_open) else $error("open outside a cycle");
    property p_loc;
        live && lo_q == 3'h7 && o_enabled && i_cfg.enable && i_loc_to_man
            |-> ##2 !o_automatic_state_led;
    endproperty
    a_loc: assert property (p_loc) else $error("local manual ignored");
    property p_rej;
        live && lo_q == 3'h7 && i_rem_to_auto && !i_loc_to_auto && !$past(i_loc_to_auto)
            && !o_automatic_state_led |-> ##2 !o_automatic_state_led;
    endproperty
    a_rej: assert property (p_rej) else $error("remote taken in local");
    property p_rem;
        live && hi_q == 3'h7 && o_enabled && i_cfg.enable && i_rem_to_auto && !i_rem_to_man
            |-> ##2 (o_automatic_state_led || !o_enabled);
    endproperty
    a_rem: assert property (p_rem) else $error("remote auto ignored");
    c_open: cover property (o_open_cmd);
    c_auto: cover property ($rose(o_automatic_state_led));
    c_end:  cover property ($fell(o_pickup));
endmodule : fis_seq_props

// *** bench/fis_partner.sv ***
// Purpose: breaker drive and remote station log
// Assumes: open command is a one-cycle pulse
// Notes:   a breaker told to refuse never reports open
`timescale 1ns/1ps
module fis_partner (
    input  wire logic       i_mclk,
    input  wire logic       i_open_cmd,
    input  wire logic       i_operation,
    input  wire logic       i_obey,
    input  wire logic       i_close,
    input  wire logic [3:0] i_dly,
    output logic            o_breaker_open,
    output int              o_ops
);
    int wait_q = 0;
    initial o_breaker_open = 1'b0;
    initial o_ops = 0;
    always @(posedge i_mclk) begin
        if (i_operation) begin
            o_ops <= o_ops + 1;
        end
        if (i_open_cmd && i_obey) begin
            wait_q <= int'(i_dly);
        end else if (wait_q > 0) begin
            wait_q <= wait_q - 1;
        end
        if (wait_q == 1) begin
            o_breaker_open <= 1'b1;
        end else if (i_close) begin
            o_breaker_open <= 1'b0;
        end
    end
endmodule : fis_partner

// *** bench/fis_seq_tb.sv ***
// Purpose: self-checking bench for fis_seq
// Assumes: tick shortened to 10 cycles, so a refused open costs a few tens of cycles
// Notes:   mode commands and fault counts drawn from a fixed seed
`timescale 1ns/1ps
module fis_seq_tb;
    logic i_mclk, i_rst_n, i_fault_passage_detector, i_voltage_present, i_voltage_absent;
    logic i_breaker_open, i_sel_remote, i_loc_to_auto, i_loc_to_man, i_rem_to_auto;
    logic i_rem_to_man, o_enabled, o_pickup, o_check_error, o_open_cmd;
    logic o_automatic_state_led, o_manual_state_led, obey, close;
    logic [3:0] dly;
    fis_pkg::fis_cfg_t i_cfg;
    fis_pkg::fis_dir_t i_fault_dir;
    fis_pkg::fis_rc_t  o_rc;
    int miscompares = 0;
    int tests_run = 0;
    int cyc = 0;
    int seed, ops, exp_ops, nf, k;
    bit exp_auto;
    // timeout covers the longest partner delay plus the pin sync
    fis_seq #(.OPEN_TMO_MS(3), .TICK_CYC(10)) i_dut (.*);
    fis_partner i_far (.i_mclk(i_mclk), .i_open_cmd(o_open_cmd), .i_operation(o_rc.operation),
        .i_obey(obey), .i_close(close), .i_dly(dly), .o_breaker_open(i_breaker_open), .o_ops(ops));
    initial begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end
    always @(posedge i_mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            final_report();
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge i_mclk);
    endtask : tick
    task automatic chk(input string nm, input logic e, input logic g);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s exp %b got %b", nm, e, g);
        end
    endtask : chk
    task automatic chk_n(input string nm, input int e, input int g);
        tests_run++;
        if (g != e) begin
            miscompares++;
            $display("BAD %s exp %0d got %0d", nm, e, g);
        end
    endtask : chk_n
    task automatic mode_ok();
        chk("auto_led", exp_auto && i_cfg.enable, o_automatic_state_led);
        chk("man_led", !exp_auto && i_cfg.enable, o_manual_state_led);
        chk("auto_mode", exp_auto && i_cfg.enable, o_rc.auto_mode);
    endtask : mode_ok
    // w: 3 local auto, 2 local manual, 1 remote auto, 0 remote manual
    task automatic pulse(input int w);
        {i_loc_to_auto, i_loc_to_man, i_rem_to_auto, i_rem_to_man} <= 4'h1 << w;
        if (i_cfg.enable && ((w > 1) != i_sel_remote)) begin
            exp_auto = w[0];
        end
        tick(1);
        {i_loc_to_auto, i_loc_to_man, i_rem_to_auto, i_rem_to_man} <= 4'h0;
        tick(5);
        mode_ok();
    endtask : pulse
    task automatic fault_cycle(input int n, input bit ob, input bit ok);
        obey <= ob;
        dly <= 4'h1 + 4'($random(seed) & 7);
        repeat (n) begin
            tick(1);
            i_fault_passage_detector <= 1'b1;
            tick(1);
            i_fault_passage_detector <= 1'b0;
        end
        i_voltage_present <= n < nf;
        i_voltage_absent <= n >= nf;
        @(negedge i_mclk);
        for (k = 0; k < 2000 && o_pickup !== 1'b0; k++) begin
            @(negedge i_mclk);
        end
        if (ok && exp_auto && n >= nf) begin
            exp_ops++;
            exp_auto = ob;
        end
        tick(1);
        {i_voltage_present, i_voltage_absent, close} <= 3'h3;
        tick(1);
        close <= 1'b0;
        tick(6);
        chk_n("ops", exp_ops, ops);
        mode_ok();
    endtask : fault_cycle
    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : final_report
    initial begin
        seed = 38;
        exp_ops = 0;
        exp_auto = 1'b0;
        {i_rst_n, i_fault_passage_detector, i_voltage_present, i_voltage_absent} = 4'h0;
        {i_sel_remote, i_loc_to_auto, i_loc_to_man, i_rem_to_auto, i_rem_to_man} = 5'h00;
        {obey, close, dly} = 6'h21;
        i_cfg = '0;
        i_fault_dir = '0;
        tick(3);
        i_rst_n <= 1'b1;
        tick(9);
        chk("enabled", 1'b0, o_enabled);
        chk("invalid", 1'b1, o_rc.invalid_qualifier);
        i_cfg <= {1'b1, 3'h2, 17'h0_0000, 17'h0_0000, 7'h7f};
        i_voltage_absent <= 1'b1;
        tick(6);
        chk("enabled", 1'b1, o_enabled);
        mode_ok();
        repeat (16) begin
            i_sel_remote <= 1'($random(seed));
            tick(8);
            pulse($random(seed) & 3);
        end
        i_sel_remote <= 1'b0;
        tick(8);
        pulse(3);
        nf = 1 + ($random(seed) & 3);
        i_cfg.num_faults <= 3'(nf);
        fault_cycle(nf, 1'b1, 1'b1);
        for (int t = 0; t < 2; t++) begin
            {i_cfg.dir_out_ok, i_cfg.dir_in_ok, i_cfg.dir_unk_ok} <= t ? 3'h1 : 3'h6;
            fault_cycle(nf, 1'b1, t[0]);
        end
        nf = 4;
        i_cfg.num_faults <= 3'h4;
        fault_cycle(1, 1'b1, 1'b1);
        fault_cycle(3, 1'b1, 1'b1);
        fault_cycle(4, 1'b0, 1'b1);
        pulse(3);
        i_cfg.fpd_en <= 1'b0;
        tick(6);
        chk("invalid", 1'b1, o_rc.invalid_qualifier);
        chk("auto_mode", 1'b0, o_rc.auto_mode);
        {i_cfg.enable, i_cfg.fpd_en} <= 2'h1;
        exp_auto = 1'b0;
        tick(6);
        i_sel_remote <= 1'b1;
        tick(8);
        pulse(1);
        chk("invalid", 1'b1, o_rc.invalid_qualifier);
        i_cfg.enable <= 1'b1;
        tick(6);
        mode_ok();
        final_report();
    end
endmodule : fis_seq_tb
bind fis_seq fis_seq_props i_props (.*);
